// *** common/clk_irq_rst_cfg.svh ***
// Offsets, field positions, reset values and the checklist of behaviour for the clock ready and reset block
// What this block does
// RULE1: Security clear one clears failure flag
// RULE2: Ext fast clear one clears ready flag
// RULE3: Int fast clear one clears ready flag
// RULE4: Ext slow clear one clears ready flag
// RULE5: Int slow clear one clears ready flag
// RULE6: PLL clear one clears PLL flag
// RULE7: PLL interrupt enable, read-write, reset zero
// RULE8: Ext fast interrupt gated by enable
// RULE9: Int fast interrupt gated by enable
// RULE10: Ext slow interrupt gated by enable
// RULE11: Int slow interrupt gated by enable
// RULE12: Clock failure sets sticky security flag
// RULE13: PLL ready sets PLL flag
// RULE14: Ext fast ready sets its flag
// RULE15: Int fast ready sets its flag
// RULE16: Ext slow ready sets its flag
// RULE17: Int slow ready sets its flag
// RULE18: Serial and SPI reset bits
// RULE19: Timer and converter reset bits
// RULE20: GPIO A to D reset bits
// RULE21: Alternate function reset bit
// RULE22: Interrupt when enabled flag or failure
// RULE23: Reset output follows its bit
`ifndef CLK_IRQ_RST_CFG_SVH
`define CLK_IRQ_RST_CFG_SVH

`define CIR_ADDR_W          4
`define CIR_OFS_IRQ         4'h0
`define CIR_OFS_PRST        4'h4
`define CIR_FLAG_LSB        0
`define CIR_FAIL_FLAG_BIT   7
`define CIR_IE_LSB          8
`define CIR_CLR_LSB         16
`define CIR_FAIL_CLR_BIT    23
`define CIR_PRST_MASK       32'h00005A3D
`define CIR_RESET_VAL       32'h00000000

`endif

// *** common/clk_irq_rst_pkg.sv ***
// Types shared by the clock ready and peripheral reset block
package clk_irq_rst_pkg;

    // Ready indications, one bit per source, same order as the flag bits
    typedef struct packed {
        logic pll_lock;
        logic ext_fast;
        logic int_fast;
        logic ext_slow;
        logic int_slow;
    } osc_ready_t;

    // Per-peripheral reset lines
    typedef struct packed {
        logic serial_port_one_reset;
        logic sync_serial_one_reset;
        logic adv_timer_reset;
        logic converter_reset;
        logic gpio_d_reset;
        logic gpio_c_reset;
        logic gpio_b_reset;
        logic gpio_a_reset;
        logic alt_function_reset;
    } periph_reset_t;

endpackage : clk_irq_rst_pkg

// *** logic/clk_irq_rst.sv ***
// Clock ready interrupt flags and fast-bus peripheral reset register
//
// Our own choice: strobed register access.
`timescale 1ns/10ps
`include "clk_irq_rst_cfg.svh"
module clk_irq_rst
(
    input  wire logic                         clk,
    input  wire logic                         srst,
    input  wire logic [`CIR_ADDR_W-1:0]       addr,
    input  wire logic [31:0]                  wdata,
    input  wire logic                         wr_stb,
    input  wire logic                         rd_stb,
    output logic      [31:0]                  rdata,
    input  wire clk_irq_rst_pkg::osc_ready_t  ready_in,
    input  wire logic                         ext_fast_fail,
    output logic                              clock_irq,
    output clk_irq_rst_pkg::periph_reset_t    periph_rst
);
    import clk_irq_rst_pkg::*;

    logic [4:0]  flag_r;
    logic [4:0]  flag_nxt;
    logic [4:0]  ien_r;
    logic        fail_flag_r;
    logic        fail_flag_nxt;
    logic [4:0]  rdy_d_r;
    logic [31:0] prst_r;
    logic [31:0] rdata_r;
    logic        irq_r;

    // Address decode and write strobes
    wire         sel_irq   = (addr == `CIR_OFS_IRQ);
    wire         sel_prst  = (addr == `CIR_OFS_PRST);
    wire         wr_irq    = wr_stb && sel_irq;
    wire         wr_prst   = wr_stb && sel_prst;
    wire [4:0]   clr_bits  = wr_irq ? wdata[`CIR_CLR_LSB +: 5] : 5'h00;
    wire         css_clr   = wr_irq && wdata[`CIR_FAIL_CLR_BIT];
    // Enable value after this cycle's write, so the interrupt follows the write at once
    wire [4:0]   ien_nxt   = wr_irq ? wdata[`CIR_IE_LSB +: 5] : ien_r;
    wire [4:0]   rdy_now   = ready_in;

    // Flags fire on the rising edge of each ready indication
    wire [4:0]   rdy_rise  = rdy_now & ~rdy_d_r;

    // Set beats clear so an edge in the clearing cycle is not lost
    assign flag_nxt = (flag_r & ~clr_bits) | rdy_rise; // RULE2 RULE3 RULE4 RULE5 RULE6 RULE13 RULE14 RULE15 RULE16 RULE17
    assign fail_flag_nxt = (fail_flag_r & ~css_clr) | ext_fast_fail; // RULE1 RULE12

    // Interrupt request from enabled flags or clock failure
    wire         irq_nxt   = (|(flag_nxt & ien_nxt)) || fail_flag_nxt; // RULE7 RULE8 RULE9 RULE10 RULE11 RULE22

    // Readback: clear bits read as zero, reserved bits as zero
    wire [31:0]  irq_view  = {24'h000000, fail_flag_r, 2'b00, flag_r} | ({27'h0000000, ien_r} << `CIR_IE_LSB);
    wire [31:0]  rd_mux    = sel_irq ? irq_view : (sel_prst ? prst_r : 32'h00000000);

    // Ready edge tracking and sticky flags
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            flag_r  <= 5'h00;
            fail_flag_r <= 1'b0;
            rdy_d_r <= 5'h00;
        end
        else
        begin
            flag_r  <= flag_nxt;
            fail_flag_r <= fail_flag_nxt;
            rdy_d_r <= rdy_now;
        end
    end

    // Software-written enables and reset bits
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ien_r  <= 5'h00; // RULE7
            prst_r <= `CIR_RESET_VAL;
        end
        else
        begin
            if (wr_irq)
                ien_r <= wdata[`CIR_IE_LSB +: 5]; // RULE8 RULE9 RULE10 RULE11
            if (wr_prst)
                prst_r <= wdata & `CIR_PRST_MASK; // RULE18 RULE19 RULE20 RULE21
        end
    end

    // Registered outputs; read data valid only the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rdata_r <= 32'h00000000;
            irq_r   <= 1'b0;
        end
        else
        begin
            rdata_r <= rd_stb ? rd_mux : 32'h00000000;
            irq_r   <= irq_nxt;
        end
    end

    assign rdata     = rdata_r;
    assign clock_irq = irq_r;

    // Reset lines mirror the register bits directly, so they hold until software writes zero
    assign periph_rst = '{serial_port_one_reset: prst_r[14], sync_serial_one_reset: prst_r[12], // RULE23
                          adv_timer_reset: prst_r[11], converter_reset: prst_r[9],
                          gpio_d_reset: prst_r[5], gpio_c_reset: prst_r[4],
                          gpio_b_reset: prst_r[3], gpio_a_reset: prst_r[2],
                          alt_function_reset: prst_r[0]};

    property p_css_set;
        @(posedge clk) disable iff (srst) ext_fast_fail |=> fail_flag_r;
    endproperty
    a_css_set: assert property (p_css_set) else $error("failure flag not set"); // RULE12

    property p_css_clr;
        @(posedge clk) disable iff (srst) (css_clr && !ext_fast_fail) |=> !fail_flag_r;
    endproperty
    a_css_clr: assert property (p_css_clr) else $error("failure flag not cleared"); // RULE1

    property p_css_hold;
        @(posedge clk) disable iff (srst) (fail_flag_r && !css_clr) |=> fail_flag_r;
    endproperty
    a_css_hold: assert property (p_css_hold) else $error("failure flag dropped"); // RULE12

    property p_pll_set;
        @(posedge clk) disable iff (srst) (ready_in.pll_lock && !$past(ready_in.pll_lock)) |=> flag_r[4];
    endproperty
    a_pll_set: assert property (p_pll_set) else $error("pll flag not set"); // RULE13

    property p_flag_clr;
        @(posedge clk) disable iff (srst) (wr_irq && wdata[16] && !rdy_rise[0]) |=> !flag_r[0];
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("ready flag not cleared"); // RULE5

    property p_flag_zero;
        @(posedge clk) disable iff (srst) (flag_r[3] && !(wr_irq && wdata[19])) |=> flag_r[3];
    endproperty
    a_flag_zero: assert property (p_flag_zero) else $error("ready flag lost"); // RULE2

    property p_irq;
        @(posedge clk) disable iff (srst) ##1 (clock_irq == ((|(flag_r & ien_r)) || fail_flag_r));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt mismatch"); // RULE22

    property p_prst;
        @(posedge clk) disable iff (srst) wr_prst |=> (periph_rst.gpio_a_reset == $past(wdata[2]))
            && (periph_rst.serial_port_one_reset == $past(wdata[14]));
    endproperty
    a_prst: assert property (p_prst) else $error("reset bit mismatch"); // RULE20

    // Each ready edge must land in its flag
    property p_efo_set;
        @(posedge clk) disable iff (srst) (ready_in.ext_fast && !$past(ready_in.ext_fast)) |=> flag_r[3];
    endproperty
    a_efo_set: assert property (p_efo_set) else $error("ext fast flag not set"); // RULE14

    property p_ifo_set;
        @(posedge clk) disable iff (srst) (ready_in.int_fast && !$past(ready_in.int_fast)) |=> flag_r[2];
    endproperty
    a_ifo_set: assert property (p_ifo_set) else $error("int fast flag not set"); // RULE15

    property p_eso_set;
        @(posedge clk) disable iff (srst) (ready_in.ext_slow && !$past(ready_in.ext_slow)) |=> flag_r[1];
    endproperty
    a_eso_set: assert property (p_eso_set) else $error("ext slow flag not set"); // RULE16

    property p_iso_set;
        @(posedge clk) disable iff (srst) (ready_in.int_slow && !$past(ready_in.int_slow)) |=> flag_r[0];
    endproperty
    a_iso_set: assert property (p_iso_set) else $error("int slow flag not set"); // RULE17

    // A flag never rises without an edge
    property p_pll_quiet;
        @(posedge clk) disable iff (srst) (!flag_r[4] && !rdy_rise[4]) |=> !flag_r[4];
    endproperty
    a_pll_quiet: assert property (p_pll_quiet) else $error("pll flag rose alone"); // RULE13

    property p_efo_quiet;
        @(posedge clk) disable iff (srst) (!flag_r[3] && !rdy_rise[3]) |=> !flag_r[3];
    endproperty
    a_efo_quiet: assert property (p_efo_quiet) else $error("ext fast flag rose alone"); // RULE14

    property p_ifo_quiet;
        @(posedge clk) disable iff (srst) (!flag_r[2] && !rdy_rise[2]) |=> !flag_r[2];
    endproperty
    a_ifo_quiet: assert property (p_ifo_quiet) else $error("int fast flag rose alone"); // RULE15

    property p_eso_quiet;
        @(posedge clk) disable iff (srst) (!flag_r[1] && !rdy_rise[1]) |=> !flag_r[1];
    endproperty
    a_eso_quiet: assert property (p_eso_quiet) else $error("ext slow flag rose alone"); // RULE16

    property p_iso_quiet;
        @(posedge clk) disable iff (srst) (!flag_r[0] && !rdy_rise[0]) |=> !flag_r[0];
    endproperty
    a_iso_quiet: assert property (p_iso_quiet) else $error("int slow flag rose alone"); // RULE17

    // A one in a clear bit drops its flag unless a new edge arrives
    property p_pll_clr;
        @(posedge clk) disable iff (srst) (wr_irq && wdata[20] && !rdy_rise[4]) |=> !flag_r[4];
    endproperty
    a_pll_clr: assert property (p_pll_clr) else $error("pll flag not cleared"); // RULE6

    property p_efo_clr;
        @(posedge clk) disable iff (srst) (wr_irq && wdata[19] && !rdy_rise[3]) |=> !flag_r[3];
    endproperty
    a_efo_clr: assert property (p_efo_clr) else $error("ext fast flag not cleared"); // RULE2

    property p_ifo_clr;
        @(posedge clk) disable iff (srst) (wr_irq && wdata[18] && !rdy_rise[2]) |=> !flag_r[2];
    endproperty
    a_ifo_clr: assert property (p_ifo_clr) else $error("int fast flag not cleared"); // RULE3

    property p_eso_clr;
        @(posedge clk) disable iff (srst) (wr_irq && wdata[17] && !rdy_rise[1]) |=> !flag_r[1];
    endproperty
    a_eso_clr: assert property (p_eso_clr) else $error("ext slow flag not cleared"); // RULE4

    // A zero in a clear bit leaves its flag alone
    property p_pll_keep;
        @(posedge clk) disable iff (srst) (flag_r[4] && !(wr_irq && wdata[20])) |=> flag_r[4];
    endproperty
    a_pll_keep: assert property (p_pll_keep) else $error("pll flag lost"); // RULE6

    property p_ifo_keep;
        @(posedge clk) disable iff (srst) (flag_r[2] && !(wr_irq && wdata[18])) |=> flag_r[2];
    endproperty
    a_ifo_keep: assert property (p_ifo_keep) else $error("int fast flag lost"); // RULE3

    property p_eso_keep;
        @(posedge clk) disable iff (srst) (flag_r[1] && !(wr_irq && wdata[17])) |=> flag_r[1];
    endproperty
    a_eso_keep: assert property (p_eso_keep) else $error("ext slow flag lost"); // RULE4

    property p_iso_keep;
        @(posedge clk) disable iff (srst) (flag_r[0] && !(wr_irq && wdata[16])) |=> flag_r[0];
    endproperty
    a_iso_keep: assert property (p_iso_keep) else $error("int slow flag lost"); // RULE5

    // Enables take the written value and hold otherwise
    property p_pll_ien;
        @(posedge clk) disable iff (srst) wr_irq |=> (ien_r[4] == $past(wdata[12]));
    endproperty
    a_pll_ien: assert property (p_pll_ien) else $error("pll enable mismatch"); // RULE7

    property p_efo_ien;
        @(posedge clk) disable iff (srst) wr_irq |=> (ien_r[3] == $past(wdata[11]));
    endproperty
    a_efo_ien: assert property (p_efo_ien) else $error("ext fast enable mismatch"); // RULE8

    property p_ifo_ien;
        @(posedge clk) disable iff (srst) wr_irq |=> (ien_r[2] == $past(wdata[10]));
    endproperty
    a_ifo_ien: assert property (p_ifo_ien) else $error("int fast enable mismatch"); // RULE9

    property p_eso_ien;
        @(posedge clk) disable iff (srst) wr_irq |=> (ien_r[1] == $past(wdata[9]));
    endproperty
    a_eso_ien: assert property (p_eso_ien) else $error("ext slow enable mismatch"); // RULE10

    property p_iso_ien;
        @(posedge clk) disable iff (srst) wr_irq |=> (ien_r[0] == $past(wdata[8]));
    endproperty
    a_iso_ien: assert property (p_iso_ien) else $error("int slow enable mismatch"); // RULE11

    property p_ien_hold;
        @(posedge clk) disable iff (srst) !wr_irq |=> $stable(ien_r);
    endproperty
    a_ien_hold: assert property (p_ien_hold) else $error("enables changed alone"); // RULE7

    // Every enabled flag and the failure flag raise the interrupt
    property p_pll_irq;
        @(posedge clk) disable iff (srst) (flag_r[4] && ien_r[4]) |-> clock_irq;
    endproperty
    a_pll_irq: assert property (p_pll_irq) else $error("pll interrupt missing"); // RULE7

    property p_efo_irq;
        @(posedge clk) disable iff (srst) (flag_r[3] && ien_r[3]) |-> clock_irq;
    endproperty
    a_efo_irq: assert property (p_efo_irq) else $error("ext fast interrupt missing"); // RULE8

    property p_ifo_irq;
        @(posedge clk) disable iff (srst) (flag_r[2] && ien_r[2]) |-> clock_irq;
    endproperty
    a_ifo_irq: assert property (p_ifo_irq) else $error("int fast interrupt missing"); // RULE9

    property p_eso_irq;
        @(posedge clk) disable iff (srst) (flag_r[1] && ien_r[1]) |-> clock_irq;
    endproperty
    a_eso_irq: assert property (p_eso_irq) else $error("ext slow interrupt missing"); // RULE10

    property p_iso_irq;
        @(posedge clk) disable iff (srst) (flag_r[0] && ien_r[0]) |-> clock_irq;
    endproperty
    a_iso_irq: assert property (p_iso_irq) else $error("int slow interrupt missing"); // RULE11

    property p_fail_irq;
        @(posedge clk) disable iff (srst) fail_flag_r |-> clock_irq;
    endproperty
    a_fail_irq: assert property (p_fail_irq) else $error("failure interrupt missing"); // RULE12

    property p_fail_quiet;
        @(posedge clk) disable iff (srst) (!fail_flag_r && !ext_fast_fail) |=> !fail_flag_r;
    endproperty
    a_fail_quiet: assert property (p_fail_quiet) else $error("failure flag rose alone"); // RULE12

    // Read data shows the register state of the strobe cycle
    property p_rd_flags;
        @(posedge clk) disable iff (srst) (rd_stb && sel_irq)
            |=> (rdata[4:0] == $past(flag_r)) && (rdata[7] == $past(fail_flag_r));
    endproperty
    a_rd_flags: assert property (p_rd_flags) else $error("flag readback mismatch"); // RULE13

    property p_rd_ien;
        @(posedge clk) disable iff (srst) (rd_stb && sel_irq) |=> (rdata[12:8] == $past(ien_r));
    endproperty
    a_rd_ien: assert property (p_rd_ien) else $error("enable readback mismatch"); // RULE7

    property p_rd_clr;
        @(posedge clk) disable iff (srst) rd_stb |=> (rdata[23:16] == 8'h00);
    endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("clear bits read nonzero"); // RULE1

    property p_rd_prst;
        @(posedge clk) disable iff (srst) (rd_stb && sel_prst) |=> (rdata == $past(prst_r));
    endproperty
    a_rd_prst: assert property (p_rd_prst) else $error("reset reg readback mismatch"); // RULE18

    // Each reset line follows its written bit and holds between writes
    property p_spi_rst;
        @(posedge clk) disable iff (srst) wr_prst |=> (periph_rst.sync_serial_one_reset == $past(wdata[12]));
    endproperty
    a_spi_rst: assert property (p_spi_rst) else $error("sync serial reset mismatch"); // RULE18

    property p_tmr_rst;
        @(posedge clk) disable iff (srst) wr_prst |=> (periph_rst.adv_timer_reset == $past(wdata[11]));
    endproperty
    a_tmr_rst: assert property (p_tmr_rst) else $error("timer reset mismatch"); // RULE19

    property p_cnv_rst;
        @(posedge clk) disable iff (srst) wr_prst |=> (periph_rst.converter_reset == $past(wdata[9]));
    endproperty
    a_cnv_rst: assert property (p_cnv_rst) else $error("converter reset mismatch"); // RULE19

    property p_gpb_rst;
        @(posedge clk) disable iff (srst) wr_prst |=> (periph_rst.gpio_b_reset == $past(wdata[3]));
    endproperty
    a_gpb_rst: assert property (p_gpb_rst) else $error("port b reset mismatch"); // RULE20

    property p_gpc_rst;
        @(posedge clk) disable iff (srst) wr_prst |=> (periph_rst.gpio_c_reset == $past(wdata[4]));
    endproperty
    a_gpc_rst: assert property (p_gpc_rst) else $error("port c reset mismatch"); // RULE20

    property p_gpd_rst;
        @(posedge clk) disable iff (srst) wr_prst |=> (periph_rst.gpio_d_reset == $past(wdata[5]));
    endproperty
    a_gpd_rst: assert property (p_gpd_rst) else $error("port d reset mismatch"); // RULE20

    property p_alt_rst;
        @(posedge clk) disable iff (srst) wr_prst |=> (periph_rst.alt_function_reset == $past(wdata[0]));
    endproperty
    a_alt_rst: assert property (p_alt_rst) else $error("alt function reset mismatch"); // RULE21

    property p_rst_hold;
        @(posedge clk) disable iff (srst) !wr_prst |=> $stable(periph_rst);
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("reset lines changed alone"); // RULE23

    // Everything starts cleared when reset lets go
    property p_reset_state;
        @(posedge clk) $fell(srst) |-> (flag_r == 5'h00) && !fail_flag_r && (ien_r == 5'h00)
            && (prst_r == `CIR_RESET_VAL);
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("state not cleared by reset"); // RULE7

endmodule : clk_irq_rst

// *** testbench/clk_irq_rst_bench.sv ***
// Self-checking bench for the clock ready flags and peripheral reset register
`timescale 1ns/10ps
module clk_irq_rst_bench;
    import clk_irq_rst_pkg::*;
    logic          clk = 1'b0;
    logic          srst = 1'b1;
    logic [3:0]    addr = 4'h0;
    logic [31:0]   wdata = 32'h0;
    logic          wr_stb = 1'b0;
    logic          rd_stb = 1'b0;
    logic [31:0]   rdata;
    osc_ready_t    ready_in = 5'h00;
    logic          ext_fast_fail = 1'b0;
    logic          clock_irq;
    periph_reset_t periph_rst;
    int            miscompares = 0;
    int            compares = 0;
    always #12.5 clk = ~clk;
    clk_irq_rst uut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .ready_in(ready_in), .ext_fast_fail(ext_fast_fail), .clock_irq(clock_irq),
        .periph_rst(periph_rst));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One-cycle strobes, released after the sampling edge
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk) addr <= a; wdata <= d; wr_stb <= 1'b1;
        @(posedge clk) wr_stb <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge clk) addr <= a; rd_stb <= 1'b1;
        @(posedge clk) rd_stb <= 1'b0;
        #1 check(what, rdata, exp);
    endtask : rd
    task automatic reset_values;
        rd(4'h0, 32'h0, "irq reg reset");
        rd(4'h4, 32'h0, "prst reg reset");
        check("irq at reset", clock_irq, 1'b0);
    endtask : reset_values
    // Each source in turn: enable, see the interrupt, clear only that flag
    task automatic ready_flags;
        logic [31:0] left;
        @(posedge clk) ready_in <= 5'h1F;
        repeat (2) @(posedge clk);
        #1 check("irq masked", clock_irq, 1'b0);
        for (int i = 0; i < 5; i++)
        begin
            left = (32'h1F >> (i + 1)) << (i + 1);
            wr(4'h0, 32'h1 << (8 + i));
            check("irq enabled", clock_irq, 1'b1);
            rd(4'h0, left | (32'h1 << i) | (32'h1 << (8 + i)), "flags set");
            wr(4'h0, (32'h1 << (8 + i)) | (32'h1 << (16 + i)));
            check("irq after clear", clock_irq, 1'b0);
            rd(4'h0, left | (32'h1 << (8 + i)), "flag cleared");
        end
    endtask : ready_flags
    // Sticky failure flag, cleared only by a one at bit 23
    task automatic failure;
        @(posedge clk) ext_fast_fail <= 1'b1;
        @(posedge clk) ext_fast_fail <= 1'b0;
        @(posedge clk);
        #1 check("irq on fail", clock_irq, 1'b1);
        wr(4'h0, 32'h0);
        rd(4'h0, 32'h80, "fail sticky");
        wr(4'h0, 32'h0080_0000);
        rd(4'h0, 32'h0, "fail cleared");
        check("irq fail gone", clock_irq, 1'b0);
    endtask : failure
    // Reset lines follow their bits; reserved bits and unmapped space read zero
    task automatic periph_resets;
        wr(4'h4, 32'h0000_4000);
        check("serial reset", periph_rst, 9'h100);
        wr(4'h4, 32'h0000_0001);
        check("altfn reset", periph_rst, 9'h001);
        wr(4'h4, 32'hFFFF_FFFF);
        check("all resets", periph_rst, 9'h1FF);
        wr(4'h8, 32'hFFFF_FFFF);
        rd(4'h4, 32'h0000_5A3D, "prst readback");
        rd(4'h8, 32'h0, "unmapped read");
        rd(4'h0, 32'h0, "irq reg untouched");
        wr(4'h4, 32'h0);
        check("resets released", periph_rst, 9'h000);
    endtask : periph_resets
    task automatic report_and_stop;
        if (miscompares == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        reset_values();
        ready_flags();
        failure();
        periph_resets();
        report_and_stop();
    end
endmodule : clk_irq_rst_bench
